// ### rtl/tcp_pkg.sv
// constants for the transceiver control pin block
package tcp_pkg;

   // register byte offsets on the AXI4-Lite bus
   localparam int           ADDR_W      = 8;
   localparam logic [7:0]   CTRL_OFS    = 8'h00;
   localparam logic [7:0]   STAT_OFS    = 8'h04;
   localparam logic [7:0]   CFG3_OFS    = 8'h08;
   localparam logic [7:0]   THR_OFS     = 8'h0c;
   localparam logic [7:0]   ISTAT_OFS   = 8'h10;
   localparam logic [7:0]   ICLR_OFS    = 8'h14;
   localparam logic [7:0]   IEN_OFS     = 8'h18;

   // user_control_reg fields
   localparam int           CTL_SOFT_TX = 0;
   localparam int           CTL_SOFT_RS = 1;
   localparam int           CTL_IRQ_SEL = 4;
   localparam logic [7:0]   CTRL_RST    = 8'h00;

   // status register fields
   localparam int           ST_TX_OFF   = 0;
   localparam int           ST_RS       = 1;
   localparam int           ST_LOSS     = 2;
   localparam int           ST_TX_DIS   = 3;

   // maker_config_reg3 fields
   localparam int           CFG_GPO_EN  = 0;
   localparam int           CFG_GPO_LVL = 1;
   localparam int           CFG_GPO_PP  = 2;
   localparam logic [7:0]   CFG3_RST    = 8'h00;

   // loss threshold reset value
   localparam logic [7:0]   THR_RST     = 8'h20;

   // interrupt event bits
   localparam int           EV_W        = 4;
   localparam int           EV_LOSS     = 0;
   localparam int           EV_TX       = 1;
   localparam int           EV_RS       = 2;
   localparam int           EV_START    = 3;
   localparam logic [3:0]   EV_RST      = 4'h0;

   // AXI responses
   localparam logic [1:0]   RESP_OKAY   = 2'h0;
   localparam logic [1:0]   RESP_SLVERR = 2'h2;

endpackage

// ### rtl/tcp_top.sv
// transceiver control pins: tx disable, rate select, loss of signal, irq pin
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
module tcp_top
   import tcp_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   input  wire logic              tx_off_in_i,
   input  wire logic              rate_sel_in_i,
   input  wire logic              signal_loss_pin_i,
   input  wire logic [7:0]        rx_power_level_i,
   input  wire logic              serial_clk_i,
   input  wire logic              serial_data_i,
   output logic                   serial_data_o,
   output logic                   serial_data_oe_o,
   output logic                   tx_disable_o,
   output logic                   rate_sel_out_o,
   output logic                   rate_sel_out_oe_o,
   output logic                   signal_loss_out_o,
   output logic                   signal_loss_out_oe_o,
   output logic                   supply_sense_pin_o,
   output logic                   supply_sense_pin_oe_o,
   output logic                   irq_o
);

   logic              tx_off_m_r;
   logic              tx_off_s_r;
   logic              rs_m_r;
   logic              rs_s_r;
   logic              los_m_r;
   logic              los_s_r;
   logic              sclk_m_r;
   logic              sclk_s_r;
   logic              sdat_m_r;
   logic              sdat_s_r;
   logic              sdat_d_r;
   logic              tx_off_d_r;
   logic              rs_d_r;
   logic              loss_r;
   logic              loss_d_r;
   logic [7:0]        user_control_reg_r;
   logic [7:0]        maker_config_reg3_r;
   logic [7:0]        loss_threshold_n_r;
   logic [3:0]        stat_r;
   logic [EV_W-1:0]   irq_stat_r;
   logic [EV_W-1:0]   irq_en_r;
   logic [EV_W-1:0]   irq_ev;
   logic [EV_W-1:0]   irq_clr;
   logic              irq_level;
   logic              aw_hold_r;
   logic              w_hold_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0]       w_data_r;
   logic [3:0]        w_strb_r;
   logic              wr_go;
   logic              rs_value;

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == CTRL_OFS) || (a == STAT_OFS) || (a == CFG3_OFS) || (a == THR_OFS)
               || (a == ISTAT_OFS) || (a == ICLR_OFS) || (a == IEN_OFS);
   endfunction

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: every pin but rx_power_level_i is outside the clock's domain; the comparator uses that bus directly
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_off_m_r <= 1'b0;
         tx_off_s_r <= 1'b0;
         rs_m_r     <= 1'b0;
         rs_s_r     <= 1'b0;
         los_m_r    <= 1'b0;
         los_s_r    <= 1'b0;
         sclk_m_r   <= 1'b1;
         sclk_s_r   <= 1'b1;
         sdat_m_r   <= 1'b1;
         sdat_s_r   <= 1'b1;
         sdat_d_r   <= 1'b1;
         tx_off_d_r <= 1'b0;
         rs_d_r     <= 1'b0;
         loss_d_r   <= 1'b0;
      end
      else
      begin
         tx_off_m_r <= tx_off_in_i;
         tx_off_s_r <= tx_off_m_r;
         rs_m_r     <= rate_sel_in_i;
         rs_s_r     <= rs_m_r;
         los_m_r    <= signal_loss_pin_i;
         los_s_r    <= los_m_r;
         sclk_m_r   <= serial_clk_i;
         sclk_s_r   <= sclk_m_r;
         sdat_m_r   <= serial_data_i;
         sdat_s_r   <= sdat_m_r;
         sdat_d_r   <= sdat_s_r;
         tx_off_d_r <= tx_off_s_r;
         rs_d_r     <= rs_s_r;
         loss_d_r   <= loss_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmitter disable
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         tx_disable_o <= 1'b1;
      else
         tx_disable_o <= tx_off_s_r | user_control_reg_r[CTL_SOFT_TX];
   end

   a_tx_dis_on: assert property ((tx_off_s_r || user_control_reg_r[CTL_SOFT_TX]) |=> tx_disable_o)
      else $error("transmitter not disabled");
   // reset leaves the transmitter disabled, so the edge that releases reset is not judged
   a_tx_dis_off: assert property ((!sys_rst_i && !(tx_off_s_r || user_control_reg_r[CTL_SOFT_TX])) |=> !tx_disable_o)
      else $error("transmitter disabled without cause");

   ////////////////////////////////////////////////////////////////////////
   // rate select / general-purpose output
   assign rs_value = rs_s_r | user_control_reg_r[CTL_SOFT_RS];

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         rate_sel_out_o    <= 1'b0;
         rate_sel_out_oe_o <= 1'b1;
      end
      else if (maker_config_reg3_r[CFG_GPO_EN])
      begin
         rate_sel_out_o    <= maker_config_reg3_r[CFG_GPO_PP] & maker_config_reg3_r[CFG_GPO_LVL];
         rate_sel_out_oe_o <= maker_config_reg3_r[CFG_GPO_PP] | ~maker_config_reg3_r[CFG_GPO_LVL];
      end
      else
      begin
         rate_sel_out_o    <= 1'b0;
         rate_sel_out_oe_o <= ~rs_value;
      end
   end

   a_rs_or_high: assert property ((!maker_config_reg3_r[CFG_GPO_EN] && rs_value) |=> !rate_sel_out_oe_o)
      else $error("rate select not released");
   a_rs_or_low: assert property ((!maker_config_reg3_r[CFG_GPO_EN] && !rs_value) |=> rate_sel_out_oe_o)
      else $error("rate select not pulled low");
   a_rs_open_drain: assert property (!maker_config_reg3_r[CFG_GPO_EN] |=> !rate_sel_out_o)
      else $error("rate select driven high");
   a_gpo_push_pull: assert property ((maker_config_reg3_r[CFG_GPO_EN] && maker_config_reg3_r[CFG_GPO_PP])
      |=> rate_sel_out_oe_o && (rate_sel_out_o == $past(maker_config_reg3_r[CFG_GPO_LVL])))
      else $error("gpo push-pull level wrong");
   a_gpo_open_drain: assert property ((maker_config_reg3_r[CFG_GPO_EN] && !maker_config_reg3_r[CFG_GPO_PP])
      |=> !rate_sel_out_o && (rate_sel_out_oe_o != $past(maker_config_reg3_r[CFG_GPO_LVL])))
      else $error("gpo open-drain drive wrong");

   ////////////////////////////////////////////////////////////////////////
   // loss of signal comparator, held between the two crossings
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         loss_r <= 1'b0;
      else if (rx_power_level_i < loss_threshold_n_r)
         loss_r <= 1'b1;
      else if (rx_power_level_i > loss_threshold_n_r)
         loss_r <= 1'b0;
   end

   // open drain, active high: pulled low in normal operation
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         signal_loss_out_o    <= 1'b0;
         signal_loss_out_oe_o <= 1'b1;
      end
      else
      begin
         signal_loss_out_o    <= 1'b0;
         signal_loss_out_oe_o <= ~loss_r;
      end
   end

   a_loss_assert: assert property ((rx_power_level_i < loss_threshold_n_r) |=> loss_r ##1 !signal_loss_out_oe_o)
      else $error("loss output not asserted");
   a_loss_release: assert property ((rx_power_level_i > loss_threshold_n_r) |=> !loss_r)
      else $error("loss output not released");

   ////////////////////////////////////////////////////////////////////////
   // status mirrors; bus writes reach only ST_TX_DIS, through the soft tx-disable bit of user_control_reg
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         stat_r <= 4'h0;
      else
      begin
         stat_r[ST_TX_OFF] <= tx_off_s_r;
         stat_r[ST_RS]     <= rs_s_r;
         stat_r[ST_LOSS]   <= los_s_r;
         stat_r[ST_TX_DIS] <= tx_disable_o;
      end
   end

   a_tx_status: assert property (tx_off_s_r |=> stat_r[ST_TX_OFF])
      else $error("tx-off status lost pin");
   a_rs_status: assert property (rs_s_r != $past(rs_s_r) |=> stat_r[ST_RS] == $past(rs_s_r))
      else $error("rate select status stale");
   a_loss_status: assert property (los_s_r |=> stat_r[ST_LOSS])
      else $error("loss status misses pin");

   ////////////////////////////////////////////////////////////////////////
   // serial port pins; the host owns the clock and the data line is never driven or pulled low
   always_ff @(posedge ref_clk_i)
   begin
      serial_data_o    <= 1'b0;
      serial_data_oe_o <= 1'b0;
   end

   a_data_low: assert property (serial_data_oe_o |-> !serial_data_o)
      else $error("serial data driven high");

   ////////////////////////////////////////////////////////////////////////
   // interrupts: set wins over a simultaneous clear
   assign irq_ev[EV_LOSS]  = loss_r & ~loss_d_r;
   assign irq_ev[EV_TX]    = tx_off_s_r ^ tx_off_d_r;
   assign irq_ev[EV_RS]    = rs_s_r ^ rs_d_r;
   assign irq_ev[EV_START] = sclk_s_r & sdat_d_r & ~sdat_s_r;
   assign irq_clr          = (wr_go && aw_addr_r == ICLR_OFS && w_strb_r[0]) ? w_data_r[EV_W-1:0] : EV_RST;
   assign irq_level        = |(irq_stat_r & irq_en_r);

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         irq_stat_r <= EV_RST;
      else
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         irq_o                 <= 1'b0;
         supply_sense_pin_o    <= 1'b0;
         supply_sense_pin_oe_o <= 1'b0;
      end
      else
      begin
         irq_o                 <= irq_level;
         supply_sense_pin_o    <= 1'b0;
         // bit 4 picks the pin role
         supply_sense_pin_oe_o <= user_control_reg_r[CTL_IRQ_SEL] & irq_level;
      end
   end

   a_irq_pin_off: assert property (!user_control_reg_r[CTL_IRQ_SEL] |=> !supply_sense_pin_oe_o)
      else $error("supply-sense pin driven in input mode");
   a_irq_pin_on: assert property ((user_control_reg_r[CTL_IRQ_SEL] && irq_level)
      |=> supply_sense_pin_oe_o && !supply_sense_pin_o)
      else $error("interrupt not on supply-sense pin");

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel: address and data taken in either order
   assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid_o;

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         aw_hold_r       <= 1'b0;
         w_hold_r        <= 1'b0;
         aw_addr_r       <= '0;
         w_data_r        <= 32'h0;
         w_strb_r        <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            s_axi_awready_o <= 1'b0;
            aw_hold_r       <= 1'b1;
            aw_addr_r       <= s_axi_awaddr_i;
         end
         else if (wr_go)
            aw_hold_r <= 1'b0;
         else if (!aw_hold_r && !s_axi_bvalid_o)
            s_axi_awready_o <= 1'b1;
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            s_axi_wready_o <= 1'b0;
            w_hold_r       <= 1'b1;
            w_data_r       <= s_axi_wdata_i;
            w_strb_r       <= s_axi_wstrb_i;
         end
         else if (wr_go)
            w_hold_r <= 1'b0;
         else if (!w_hold_r && !s_axi_bvalid_o)
            s_axi_wready_o <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
         s_axi_bvalid_o <= 1'b0;
   end

   // only byte lane 0 carries stored bits; status offset takes no write
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         user_control_reg_r  <= CTRL_RST;
         maker_config_reg3_r <= CFG3_RST;
         loss_threshold_n_r  <= THR_RST;
         irq_en_r            <= EV_RST;
      end
      else if (wr_go && w_strb_r[0])
      begin
         unique case (aw_addr_r)
            CTRL_OFS: user_control_reg_r  <= w_data_r[7:0];
            CFG3_OFS: maker_config_reg3_r <= w_data_r[7:0];
            THR_OFS:  loss_threshold_n_r  <= w_data_r[7:0];
            IEN_OFS:  irq_en_r            <= w_data_r[EV_W-1:0];
            default:  ;
         endcase
      end
   end

   a_status_ro: assert property ((wr_go && aw_addr_r == STAT_OFS) |=> stat_r[ST_TX_OFF] == $past(tx_off_s_r))
      else $error("status altered by write");

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0;
         s_axi_rresp_o   <= RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rresp_o   <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr_i)
            CTRL_OFS:  s_axi_rdata_o <= {24'h0, user_control_reg_r};
            STAT_OFS:  s_axi_rdata_o <= {28'h0, stat_r};
            CFG3_OFS:  s_axi_rdata_o <= {24'h0, maker_config_reg3_r};
            THR_OFS:   s_axi_rdata_o <= {24'h0, loss_threshold_n_r};
            ISTAT_OFS: s_axi_rdata_o <= {28'h0, irq_stat_r};
            IEN_OFS:   s_axi_rdata_o <= {28'h0, irq_en_r};
            default:   s_axi_rdata_o <= 32'h0;
         endcase
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
      begin
         s_axi_rvalid_o  <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
      else if (!s_axi_rvalid_o)
         s_axi_arready_o <= 1'b1;
   end

endmodule

// ### verification/tcp_host_model.sv
// host-side model of the two-wire serial port
module tcp_host_model
(
   input  wire logic go_i,
   input  wire logic dev_data_i,
   input  wire logic dev_data_oe_i,
   output logic      clk_o,
   output logic      data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv_low;
   // open-drain data line
   // pulled up unless some party pulls it low
   assign data_o = (drv_low || (dev_data_oe_i && !dev_data_i)) ? 1'b0 : 1'b1;
   initial
   begin
      clk_o = 1'b1;
      drv_low = 1'b0;
   end
   // host clocks frame
   // the clock stands high outside frames; a start is data falling with clock high
   always @(posedge go_i)
   begin
      drv_low = 1'b1;
      #80 clk_o = 1'b0;
      repeat (8)
      begin
         #40 drv_low = ~drv_low;
         #40 clk_o = 1'b1;
         #80 clk_o = 1'b0;
      end
      #40 drv_low = 1'b1;
      #40 clk_o = 1'b1;
      #80 drv_low = 1'b0;
   end
endmodule

// ### verification/tb_top.sv
// self-checking bench for the transceiver control pin block
module tb_top
   import tcp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1;
   logic [7:0]  awaddr = '0, araddr = '0, rx_pwr = 8'h80;
   logic [31:0] wdata = '0;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        tx_pin = 0, rs_pin = 0, ext_low = 0, go = 0;
   logic        awready, wready, bvalid, arready, rvalid, ser_clk, ser_data, sd_o, sd_oe;
   logic        txd, rs_o, rs_oe, lo_o, lo_oe, ss_o, ss_oe, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          err_total = 0, n_checks = 0, cyc = 0;
   // pulled-up wires: any open-drain party pulling low wins
   wire         loss_pin = ((lo_oe && !lo_o) || ext_low) ? 1'b0 : 1'b1;
   wire         rs_wire  = rs_oe ? rs_o : 1'b1;
   wire         ss_wire  = ss_oe ? ss_o : 1'b1;

   always #5 clk = ~clk;

   tcp_top tcp_top_inst (
      .ref_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .tx_off_in_i(tx_pin), .rate_sel_in_i(rs_pin), .signal_loss_pin_i(loss_pin),
      .rx_power_level_i(rx_pwr), .serial_clk_i(ser_clk), .serial_data_i(ser_data),
      .serial_data_o(sd_o), .serial_data_oe_o(sd_oe), .tx_disable_o(txd), .rate_sel_out_o(rs_o),
      .rate_sel_out_oe_o(rs_oe), .signal_loss_out_o(lo_o), .signal_loss_out_oe_o(lo_oe),
      .supply_sense_pin_o(ss_o), .supply_sense_pin_oe_o(ss_oe), .irq_o(irq));

   tcp_host_model tcp_host_model_inst (
      .go_i(go), .dev_data_i(sd_o), .dev_data_oe_i(sd_oe), .clk_o(ser_clk), .data_o(ser_data));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      @(posedge clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end
      while (awvalid || wvalid);
      while (bvalid !== 1'b1) @(posedge clk);
      bready <= 1'b0;
      chk("bresp", bresp, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OKAY);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      rready <= 1'b0;
      chk("rdata", rdata, ed);
      chk("rresp", rresp, er);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(CTRL_OFS, 32'h0);
      rd(CFG3_OFS, 32'h0);
      rd(THR_OFS, 32'h20);
      rd(ISTAT_OFS, 32'h0);
      rd(IEN_OFS, 32'h0);
      rd(ICLR_OFS, 32'h0);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(8'h40, 32'h5, RESP_SLVERR);
      chk("txd", txd, 1'b0);
      chk("ss_oe", ss_oe, 1'b0);
      chk("loss_oe", lo_oe, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_tx;
      tx_pin <= 1'b1;
      wt(5);
      chk("txd pin", txd, 1'b1);
      rd(STAT_OFS, 32'h9);
      tx_pin <= 1'b0;
      wr(CTRL_OFS, 32'h1 << CTL_SOFT_TX);
      wt(5);
      chk("txd soft", txd, 1'b1);
      rd(STAT_OFS, 32'h8);
      wr(STAT_OFS, 32'hff);
      rd(STAT_OFS, 32'h8);
      wr(CTRL_OFS, 32'h0);
      wt(5);
      chk("txd off", txd, 1'b0);
      $display("test tx done");
   endtask

   task automatic t_rate;
      wr(ICLR_OFS, 32'hf);
      for (int i = 0; i < 4; i++)
      begin
         rs_pin <= i[0];
         wr(CTRL_OFS, {30'h0, i[1], 1'b0});
         wt(5);
         chk("rs wire", rs_wire, i[0] | i[1]);
         chk("rs push", rs_oe & rs_o, 1'b0);
         rd(STAT_OFS, {30'h0, i[0], 1'b0});
      end
      rs_pin <= 1'b0;
      wr(CTRL_OFS, 32'h0);
      rd(ISTAT_OFS, 32'h1 << EV_RS);
      $display("test rate done");
   endtask

   task automatic t_gpo;
      for (int i = 0; i < 4; i++)
      begin
         wr(CFG3_OFS, {29'h0, i[1], i[0], 1'b1});
         wt(3);
         chk("gpo level", rs_wire, i[0]);
         chk("gpo drive", rs_oe, i[1] | !i[0]);
      end
      wr(CFG3_OFS, 32'h0);
      $display("test gpo done");
   endtask

   task automatic t_loss;
      wr(ICLR_OFS, 32'hf);
      wr(THR_OFS, 32'h40);
      rx_pwr <= 8'h3f;
      wt(4);
      chk("loss low", lo_oe, 1'b0);
      chk("loss pin", loss_pin, 1'b1);
      rd(STAT_OFS, 32'h4);
      rd(ISTAT_OFS, 32'h1 << EV_LOSS);
      // another circuit pulls the wire low: status follows the wire, not the comparator
      ext_low <= 1'b1;
      wt(5);
      rd(STAT_OFS, 32'h0);
      chk("loss ext", lo_oe, 1'b0);
      ext_low <= 1'b0;
      rx_pwr <= 8'h40;
      wt(4);
      chk("loss equal", lo_oe, 1'b0);
      rx_pwr <= 8'h41;
      wt(4);
      chk("loss gone", lo_oe, 1'b1);
      rd(STAT_OFS, 32'h0);
      $display("test loss done");
   endtask

   task automatic t_irq;
      wr(ICLR_OFS, 32'hf);
      wr(IEN_OFS, 32'h1 << EV_TX);
      wr(CTRL_OFS, 32'h1 << CTL_IRQ_SEL);
      chk("irq idle", irq, 1'b0);
      chk("ss idle", ss_wire, 1'b1);
      tx_pin <= 1'b1;
      wt(6);
      chk("irq set", irq, 1'b1);
      chk("ss low", ss_wire, 1'b0);
      rd(ISTAT_OFS, 32'h1 << EV_TX);
      wr(IEN_OFS, 32'h0);
      tx_pin <= 1'b0;
      wt(6);
      chk("irq mask", irq, 1'b0);
      chk("ss mask", ss_wire, 1'b1);
      wr(IEN_OFS, 32'h1 << EV_TX);
      wt(2);
      chk("irq unmask", irq, 1'b1);
      wr(CTRL_OFS, 32'h0);
      wt(2);
      chk("ss analog", ss_oe, 1'b0);
      wr(ICLR_OFS, 32'h1 << EV_TX);
      wt(2);
      chk("irq clr", irq, 1'b0);
      rd(ISTAT_OFS, 32'h0);
      $display("test irq done");
   endtask

   task automatic t_serial;
      logic bad;
      bad = 1'b0;
      wr(IEN_OFS, 32'h1 << EV_START);
      go <= 1'b1;
      repeat (200)
      begin
         @(posedge clk);
         if (sd_oe !== 1'b0) bad = 1'b1;
      end
      chk("data drive", bad, 1'b0);
      chk("irq start", irq, 1'b1);
      rd(ISTAT_OFS, 32'h1 << EV_START);
      go <= 1'b0;
      wr(ICLR_OFS, 32'hf);
      $display("test serial done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // cuts a hang short well beyond the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         test_done();
      end
   end

   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wt(2);
      t_reset();
      t_tx();
      t_rate();
      t_gpo();
      t_loss();
      t_irq();
      t_serial();
      test_done();
   end
endmodule
